// >>> common/tmcs_pkg.sv
// Shared constants and types of the torque-mode command selector.
// Assumes a 125 MHz bus clock and a 32-bit register bus.
package tmcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CTRL_PERIOD_US = 1000;  // Control cycle, one ms
    localparam int CTRL_CYCLES    = (CTRL_PERIOD_US * 1000) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register indices (byte address = 4 * index)
    localparam logic [4:0] IDX_CTRL    = 5'h00;
    localparam logic [4:0] IDX_TQ1     = 5'h01;
    localparam logic [4:0] IDX_TQ3     = 5'h03;
    localparam logic [4:0] IDX_TQFS    = 5'h04;
    localparam logic [4:0] IDX_TQOFS   = 5'h05;
    localparam logic [4:0] IDX_FLTTC   = 5'h06;
    localparam logic [4:0] IDX_TLIM1   = 5'h07;
    localparam logic [4:0] IDX_TLIM2   = 5'h08;
    localparam logic [4:0] IDX_SPD1    = 5'h09;
    localparam logic [4:0] IDX_SPD7    = 5'h0F;
    localparam logic [4:0] IDX_SPDFS   = 5'h10;
    localparam logic [4:0] IDX_INERTIA = 5'h11;
    localparam logic [4:0] IDX_PGAIN   = 5'h12;
    localparam logic [4:0] IDX_VGAIN   = 5'h13;
    localparam logic [4:0] IDX_VINT    = 5'h14;
    localparam logic [4:0] IDX_ST_TQ   = 5'h15;
    localparam logic [4:0] IDX_ST_SPD  = 5'h16;
    localparam logic [4:0] IDX_ST_SEL  = 5'h17;
    localparam int         NRW         = 21;   // Writable registers 0..20

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_TLSEL_BIT  = 0;  // Limit select input assigned
    localparam int CTRL_SP3_BIT    = 1;  // Third speed select assigned
    localparam int CTRL_TQMODE_BIT = 2;  // Torque control mode active
    localparam int CTRL_INTERP_LSB = 4;  // Two-bit interpolation mode

    typedef enum logic [1:0] {
        TMCS_MANUAL,
        TMCS_INTERP_ONE,
        TMCS_INTERP_TWO
    } tmcs_interp_e;

    ////////////////////////////////////////////////////////////////////////
    // Setting ranges
    localparam int TQ_STORED_MAX = 300;
    localparam int TQ_FS_MAX     = 2000;
    localparam int TQ_OFS_MAX    = 8000;
    localparam int FLT_TC_MAX    = 5000;
    localparam int TLIM_MAX      = 100;
    localparam int SPD_FS_MAX    = 30000;
    localparam int INERTIA_MAX   = 1200;
    localparam int PGAIN_MIN     = 4;
    localparam int PGAIN_MAX     = 1024;
    localparam int MV_PER_VOLT10 = 10000;  // Ten volts in millivolts
    localparam int TQ_SCALE      = 10;     // Torque in tenths of percent

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] RST_CTRL    = 16'h0004;
    localparam logic [15:0] RST_TQ      = 16'h0000;
    localparam logic [15:0] RST_TQFS    = 16'h0064;  // 100 %
    localparam logic [15:0] RST_TQOFS   = 16'h0000;
    localparam logic [15:0] RST_FLTTC   = 16'h0000;
    localparam logic [15:0] RST_TLIM    = 16'h0064;  // 100 %
    localparam logic [15:0] RST_SPD1    = 16'h0064;  // 100 rpm
    localparam logic [15:0] RST_SPD2    = 16'h01F4;  // 500 rpm
    localparam logic [15:0] RST_SPD3    = 16'h03E8;  // 1000 rpm
    localparam logic [15:0] RST_SPD4    = 16'h00C8;  // 200 rpm
    localparam logic [15:0] RST_SPD5    = 16'h012C;  // 300 rpm
    localparam logic [15:0] RST_SPD6    = 16'h01F4;  // 500 rpm
    localparam logic [15:0] RST_SPD7    = 16'h0320;  // 800 rpm
    localparam logic [15:0] RST_SPDFS   = 16'h0BB8;  // 3000 rpm
    localparam logic [15:0] RST_INERTIA = 16'h0046;
    localparam logic [15:0] RST_PGAIN   = 16'h002D;
    localparam logic [15:0] RST_VGAIN   = 16'h00B7;
    localparam logic [15:0] RST_VINT    = 16'h0022;

    localparam logic [NRW-1:0][15:0] RST_REGS = {
        RST_VINT, RST_VGAIN, RST_PGAIN, RST_INERTIA, RST_SPDFS,
        RST_SPD7, RST_SPD6, RST_SPD5, RST_SPD4, RST_SPD3, RST_SPD2,
        RST_SPD1, RST_TLIM, RST_TLIM, RST_FLTTC, RST_TQOFS, RST_TQFS,
        RST_TQ, RST_TQ, RST_TQ, RST_CTRL};

    ////////////////////////////////////////////////////////////////////////
    // Carriers: select terminals (1 = open) and estimated gains
    typedef struct packed {
        logic torque_source_sel_lo_n;
        logic torque_source_sel_hi_n;
        logic torque_limit_select_n;
        logic speed_sel_bit0_n;
        logic speed_sel_bit1_n;
        logic speed_sel_bit2_n;
    } tmcs_di_s;

    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] vel_gain;
        logic [15:0] vel_integral;
    } tmcs_est_s;

endpackage

// >>> src/tmcs_lpf.sv
// First-order low-pass stage for the torque command.
// Assumes one tick per control cycle and a time constant in ms.
`timescale 1ns/1ns
module tmcs_lpf (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               ce,
    input  wire logic               tick,
    input  wire logic               bypass,
    input  wire logic [15:0]        tc,
    input  wire logic signed [31:0] x,
    output logic signed [31:0]      y
);

    typedef struct packed {
        logic signed [39:0] acc;  // Filter state, eight fraction bits
    } tmcs_lpf_s;

    tmcs_lpf_s          st_ff;
    tmcs_lpf_s          nxt_st;
    logic signed [39:0] x_scaled;
    logic signed [39:0] den;

    ////////////////////////////////////////////////////////////////////////
    // State update: y += (x - y) / (tc + 1) per control cycle
    assign x_scaled = {{8{x[31]}}, x} <<< 8;
    assign den      = $signed({24'h000000, tc}) + 40'sh0000000001;

    always_comb begin
        nxt_st = st_ff;
        if (tick) begin
            if (bypass || tc == 16'h0000) begin
                nxt_st.acc = x_scaled;
            end else begin
                nxt_st.acc = st_ff.acc + (x_scaled - st_ff.acc) / den;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // Bypass takes the input straight, no lag outside torque mode
    assign y = bypass ? x : 32'(st_ff.acc >>> 8);

endmodule

// >>> src/tmcs_top.sv
// Torque-mode command selector with AHB-Lite register slave.
// Assumes select terminals synchronous to hclk and analog inputs
// already converted to signed millivolts.
`timescale 1ns/1ns

module tmcs_top #(
    parameter bit          ENHANCED    = 1'b1,
    parameter int          CTRL_CYCLES = tmcs_pkg::CTRL_CYCLES,
    parameter logic [15:0] MAX_SPEED   = 16'h1770
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ce,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire tmcs_pkg::tmcs_di_s  di,
    input  wire logic signed [15:0]  analog_torque_mv,
    input  wire logic signed [15:0]  analog_speed_input_mv,
    input  wire tmcs_pkg::tmcs_est_s est,
    output logic signed [15:0]       torque_cmd,
    output logic [6:0]               torque_limit_act,
    output logic [15:0]              speed_limit
);

    typedef struct packed {
        logic [tmcs_pkg::NRW-1:0][15:0] regs;
        logic                           wr_pend;
        logic [4:0]                     wr_idx;
        logic [31:0]                    rdata;
        logic [31:0]                    tick_cnt;
        logic signed [15:0]             torque_cmd;
        logic [6:0]                     tlim;
        logic [15:0]                    spd_lim;
        logic [1:0]                     tq_src;
        logic [2:0]                     spd_code;
    } tmcs_top_s;

    tmcs_top_s              st_ff;
    tmcs_top_s              nxt_st;
    logic                   tick;
    logic [1:0]             tq_src;
    logic [2:0]             spd_code;
    logic                   tl_on;
    logic signed [31:0]     corr_mv;
    logic signed [31:0]     raw_tq;
    logic signed [31:0]     filt_tq;
    logic signed [31:0]     lim_tq;
    logic [6:0]             lim_pct;
    logic [31:0]            an_spd;
    logic [15:0]            spd_sel;
    logic [4:0]             addr_idx;
    tmcs_pkg::tmcs_interp_e imode;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Sign-extend a stored 16-bit setting
    function automatic logic signed [31:0] sx(input logic [15:0] v);
        sx = {{16{v[15]}}, v};
    endfunction

    // Saturate a signed value into lo..hi
    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                               input int lo, input int hi);
        if (v < lo) begin
            sat = lo;
        end else if (v > hi) begin
            sat = hi;
        end else begin
            sat = v;
        end
    endfunction

    // Range check applied to every software write except to control, VGAIN and VINT, which pass unchanged
    function automatic logic [15:0] wr_clamp(input logic [4:0] idx,
                                             input logic [31:0] d,
                                             input logic [15:0] vmax);
        logic signed [31:0] s;
        s = sx(d[15:0]);
        if (idx >= tmcs_pkg::IDX_TQ1 && idx <= tmcs_pkg::IDX_TQ3) begin
            wr_clamp = 16'(sat(s, -tmcs_pkg::TQ_STORED_MAX,
                               tmcs_pkg::TQ_STORED_MAX));
        end else if (idx == tmcs_pkg::IDX_TQFS) begin
            wr_clamp = 16'(sat(s, 0, tmcs_pkg::TQ_FS_MAX));
        end else if (idx == tmcs_pkg::IDX_TQOFS) begin
            wr_clamp = 16'(sat(s, -tmcs_pkg::TQ_OFS_MAX,
                               tmcs_pkg::TQ_OFS_MAX));
        end else if (idx == tmcs_pkg::IDX_FLTTC) begin
            wr_clamp = 16'(sat(s, 0, tmcs_pkg::FLT_TC_MAX));
        end else if (idx == tmcs_pkg::IDX_TLIM1 ||
                     idx == tmcs_pkg::IDX_TLIM2) begin
            wr_clamp = 16'(sat(s, 0, tmcs_pkg::TLIM_MAX));
        end else if (idx >= tmcs_pkg::IDX_SPD1 &&
                     idx <= tmcs_pkg::IDX_SPD7) begin
            wr_clamp = 16'(sat(s, 0, int'(vmax)));
        end else if (idx == tmcs_pkg::IDX_SPDFS) begin
            wr_clamp = (d[15:0] > 16'(tmcs_pkg::SPD_FS_MAX)) ?
                       16'(tmcs_pkg::SPD_FS_MAX) : d[15:0];
        end else if (idx == tmcs_pkg::IDX_INERTIA) begin
            wr_clamp = 16'(sat(s, 0, tmcs_pkg::INERTIA_MAX));
        end else if (idx == tmcs_pkg::IDX_PGAIN) begin
            wr_clamp = 16'(sat(s, tmcs_pkg::PGAIN_MIN,
                               tmcs_pkg::PGAIN_MAX));
        end else begin
            wr_clamp = d[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control-cycle tick
    assign tick = ce && (st_ff.tick_cnt == 32'(CTRL_CYCLES - 1));

    // Interpolation mode two exists only on the enhanced variant
    always_comb begin
        unique case (st_ff.regs[tmcs_pkg::IDX_CTRL]
                     [tmcs_pkg::CTRL_INTERP_LSB +: 2])
            2'h1:    imode = tmcs_pkg::TMCS_INTERP_ONE;
            2'h2:    imode = ENHANCED ? tmcs_pkg::TMCS_INTERP_TWO
                                      : tmcs_pkg::TMCS_INTERP_ONE;
            default: imode = tmcs_pkg::TMCS_MANUAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Select inputs: open terminal reads 0, shorted reads 1
    assign tq_src = ENHANCED ? {~di.torque_source_sel_hi_n,
                                ~di.torque_source_sel_lo_n}
                             : 2'h0;
    assign tl_on  = ~di.torque_limit_select_n &&
                    st_ff.regs[tmcs_pkg::IDX_CTRL]
                              [tmcs_pkg::CTRL_TLSEL_BIT];
    assign spd_code = {~di.speed_sel_bit2_n &&
                       st_ff.regs[tmcs_pkg::IDX_CTRL]
                                 [tmcs_pkg::CTRL_SP3_BIT],
                       ~di.speed_sel_bit1_n, ~di.speed_sel_bit0_n};

    ////////////////////////////////////////////////////////////////////////
    // Torque source, in tenths of a percent of rated torque
    assign corr_mv = sx(analog_torque_mv) -
                     sx(st_ff.regs[tmcs_pkg::IDX_TQOFS]);

    always_comb begin
        if (tq_src == 2'h0) begin
            raw_tq = corr_mv * sx(st_ff.regs[tmcs_pkg::IDX_TQFS]) *
                     tmcs_pkg::TQ_SCALE /
                     tmcs_pkg::MV_PER_VOLT10;
        end else begin
            raw_tq = sx(st_ff.regs[tmcs_pkg::IDX_TQ1 +
                                   {3'h0, tq_src} - 5'h01]) *
                     tmcs_pkg::TQ_SCALE;
        end
    end

    // Command smoothing, bypassed outside torque mode
    tmcs_lpf u_lpf (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .tick    (tick),
        .bypass  (~st_ff.regs[tmcs_pkg::IDX_CTRL]
                             [tmcs_pkg::CTRL_TQMODE_BIT]),
        .tc      (st_ff.regs[tmcs_pkg::IDX_FLTTC]),
        .x       (raw_tq),
        .y       (filt_tq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Active torque limit and symmetric clamp
    always_comb begin
        if (tl_on && st_ff.regs[tmcs_pkg::IDX_TLIM2] <
                     st_ff.regs[tmcs_pkg::IDX_TLIM1]) begin
            lim_pct = st_ff.regs[tmcs_pkg::IDX_TLIM2][6:0];
        end else begin
            lim_pct = st_ff.regs[tmcs_pkg::IDX_TLIM1][6:0];
        end
        lim_tq = sat(filt_tq, -(int'(lim_pct) * tmcs_pkg::TQ_SCALE),
                     int'(lim_pct) * tmcs_pkg::TQ_SCALE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed limit selection, magnitude in rpm
    always_comb begin
        an_spd = 32'(sat(analog_speed_input_mv < 0 ?
                         -sx(analog_speed_input_mv) :
                         sx(analog_speed_input_mv), 0, 32767) *
                     sx(st_ff.regs[tmcs_pkg::IDX_SPDFS]) /
                     tmcs_pkg::MV_PER_VOLT10);
        if (spd_code == 3'h0) begin
            spd_sel = (an_spd > 32'(MAX_SPEED)) ? MAX_SPEED
                                                : an_spd[15:0];
        end else begin
            spd_sel = st_ff.regs[tmcs_pkg::IDX_SPD1 +
                                 {2'h0, spd_code} - 5'h01];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus address: word index, anything above the map is unmapped
    assign addr_idx = (haddr[31:7] != 25'h0) ? 5'h1F : haddr[6:2];

    // Next state: bus write, gain estimation, outputs, bus read
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.wr_pend  = 1'b0;
        nxt_st.tick_cnt = tick ? 32'h0 : st_ff.tick_cnt + 32'h1;
        // Data phase of a write; estimated gains refuse writes
        if (st_ff.wr_pend && st_ff.wr_idx < 5'(tmcs_pkg::NRW) &&
            !(imode == tmcs_pkg::TMCS_INTERP_ONE &&
              st_ff.wr_idx == tmcs_pkg::IDX_INERTIA) &&
            !(imode != tmcs_pkg::TMCS_MANUAL &&
              (st_ff.wr_idx == tmcs_pkg::IDX_VGAIN ||
               st_ff.wr_idx == tmcs_pkg::IDX_VINT))) begin
            nxt_st.regs[st_ff.wr_idx] = wr_clamp(st_ff.wr_idx, hwdata,
                                                 MAX_SPEED);
        end
        // Estimated gains load once per control cycle
        if (tick && imode != tmcs_pkg::TMCS_MANUAL) begin
            nxt_st.regs[tmcs_pkg::IDX_VGAIN] = est.vel_gain;
            nxt_st.regs[tmcs_pkg::IDX_VINT]  = est.vel_integral;
            if (imode == tmcs_pkg::TMCS_INTERP_ONE) begin
                nxt_st.regs[tmcs_pkg::IDX_INERTIA] = est.inertia;
            end
        end
        nxt_st.torque_cmd = 16'(lim_tq);
        nxt_st.tlim       = lim_pct;
        nxt_st.spd_lim    = spd_sel;
        nxt_st.tq_src     = tq_src;
        nxt_st.spd_code   = spd_code;
        // Address phase; reads see a write finishing this cycle
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                nxt_st.wr_pend = 1'b1;
                nxt_st.wr_idx  = addr_idx;
            end else if (addr_idx < 5'(tmcs_pkg::NRW)) begin
                nxt_st.rdata = (addr_idx == tmcs_pkg::IDX_CTRL) ?
                               {16'h0, nxt_st.regs[addr_idx]} :
                               sx(nxt_st.regs[addr_idx]);
            end else if (addr_idx == tmcs_pkg::IDX_ST_TQ) begin
                nxt_st.rdata = sx(st_ff.torque_cmd);
            end else if (addr_idx == tmcs_pkg::IDX_ST_SPD) begin
                nxt_st.rdata = {16'h0, st_ff.spd_lim};
            end else if (addr_idx == tmcs_pkg::IDX_ST_SEL) begin
                nxt_st.rdata = {16'h0, 2'h0, imode, st_ff.spd_code,
                                st_ff.tq_src, st_ff.tlim};
            end else begin
                nxt_st.rdata = 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff      <= '0;
            st_ff.regs <= tmcs_pkg::RST_REGS;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // Zero-wait, always OKAY slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Outputs straight from the state register
    assign hrdata           = st_ff.rdata;
    assign torque_cmd       = st_ff.torque_cmd;
    assign torque_limit_act = st_ff.tlim;
    assign speed_limit      = st_ff.spd_lim;

endmodule

// >>> testbench/tmcs_props.sv
// Port checker for the torque-mode command selector.
// Assumes binding to tmcs_top with hready fed from hreadyout.
`timescale 1ns/1ns
module tmcs_props #(
    parameter logic [15:0] MAX_SPEED = 16'h1770
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                ce,
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    input wire tmcs_pkg::tmcs_di_s  di,
    input wire logic signed [15:0]  analog_speed_input_mv,
    input wire logic signed [15:0]  torque_cmd,
    input wire logic [6:0]          torque_limit_act,
    input wire logic [15:0]         speed_limit
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    // Read taken and torque magnitude
    logic        rd_take;
    logic [15:0] tq_mag;
    assign rd_take = hsel && hready && htrans[1] && !hwrite && ce;
    assign tq_mag  = torque_cmd[15] ? -torque_cmd : torque_cmd;

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    a_limit_range: assert property (torque_limit_act <= 7'd100)
        else $error("active limit above 100");
    a_torque_clamp: assert property (tq_mag <= torque_limit_act * 10)
        else $error("torque beyond active limit");
    a_speed_cap: assert property (speed_limit <= MAX_SPEED)
        else $error("speed limit above permissible speed");
    a_speed_zero: assert property (ce && di[2:0] == 3'h7 &&
        analog_speed_input_mv == 16'sh0 |=> speed_limit == 16'h0)
        else $error("zero volts gave nonzero speed limit");
    a_select_min: assert property (ce && $fell(di.torque_limit_select_n)
        && !hsel && !$past(hsel)
        |=> torque_limit_act <= $past(torque_limit_act))
        else $error("limit grew on select");
    a_freeze_ce: assert property (!ce |=> $stable(torque_cmd)
        && $stable(speed_limit) && $stable(torque_limit_act))
        else $error("outputs moved with ce low");
    a_data_stands: assert property (!rd_take |=> $stable(hrdata))
        else $error("hrdata changed without read");
endmodule

bind tmcs_top tmcs_props #(.MAX_SPEED(MAX_SPEED)) i_tmcs_props (.hclk,
    .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .di, .analog_speed_input_mv, .torque_cmd, .torque_limit_act,
    .speed_limit);

// >>> testbench/tmcs_host.sv
// Host controller model: select terminals and estimator values.
// Assumes codes from the bench, 1 meaning shorted to common.
`timescale 1ns/1ns
module tmcs_host (
    input  wire logic          hclk,
    input  wire logic [1:0]    tq_code,
    input  wire logic          tl_on,
    input  wire logic [2:0]    spd_code,
    output tmcs_pkg::tmcs_di_s  di,
    output tmcs_pkg::tmcs_est_s est
);
    // Shorted terminal is low, so level is the inverse of the code
    always @(posedge hclk) begin
        di <= ~{tq_code[0], tq_code[1], tl_on, spd_code[0], spd_code[1],
                spd_code[2]};
    end
    // Estimator outputs, fixed
    assign est = {16'h0123, 16'h0456, 16'h0078};
endmodule

// >>> testbench/test_tmcs_top.sv
// Bench for the selector: AHB-Lite master and discrete-input host.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ns
module test_tmcs_top;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               ce = 1'b1;
    logic               hsel = 1'b0;
    logic        [31:0] haddr = 32'h0;
    logic        [1:0]  htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic        [31:0] hwdata = 32'h0;
    logic signed [15:0] a_tq = 16'sh0;
    logic signed [15:0] a_sp = 16'sh0;
    logic        [1:0]  tq_code = 2'h0;
    logic               tl_on = 1'b0;
    logic        [2:0]  spd_code = 3'h0;
    logic               hreadyout;
    logic               hresp;
    logic        [31:0] hrdata;
    logic        [31:0] rd;
    logic signed [15:0] torque_cmd;
    logic signed [15:0] tq_basic;
    logic        [6:0]  torque_limit_act;
    logic        [15:0] speed_limit;
    tmcs_pkg::tmcs_di_s  di;
    tmcs_pkg::tmcs_est_s est;
    int                 num_errors = 0;
    int                 comparisons = 0;
    int                 spd_a[8] = '{1500, 100, 500, 1000,
                                     1500, 100, 500, 1000};
    int                 spd_b[8] = '{1500, 100, 500, 1000, 200, 300, 500, 800};

    tmcs_top #(.CTRL_CYCLES(8)) i_tmcs_top (.hclk, .hresetn, .ce, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .di,
        .analog_torque_mv(a_tq), .analog_speed_input_mv(a_sp), .est,
        .torque_cmd, .torque_limit_act, .speed_limit);
    tmcs_top #(.ENHANCED(1'b0), .CTRL_CYCLES(8)) i_tmcs_top_basic (.hclk,
        .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .di, .analog_torque_mv(a_tq), .analog_speed_input_mv(a_sp), .est,
        .torque_cmd(tq_basic), .torque_limit_act(), .speed_limit());
    tmcs_host i_tmcs_host (.hclk, .tq_code, .tl_on, .spd_code, .di, .est);

    initial begin
        forever #4 hclk = ~hclk;
    end
    ////////////////////////////////////////
    // Comparison, bus cycle and settling helpers
    task automatic check(input logic signed [31:0] seen,
                         input logic signed [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %0d want %0d", $time, seen, exp);
        end
    endtask
    task automatic bus(input int i, input logic w, input int wd);
        hsel <= 1'b1;
        haddr <= 32'(4 * i);
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(wd);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input int i, input int d);
        bus(i, 1'b1, d);
    endtask
    task automatic settle;
        repeat (20) @(posedge hclk);
    endtask
    ////////////////////////////////////////
    // Scenarios
    task automatic t_defaults;
        for (int i = 0; i < tmcs_pkg::NRW; i++) begin
            bus(i, 1'b0, 0);
            check(rd, {16'h0, tmcs_pkg::RST_REGS[i]});
        end
        wr(32, 32'h1234);
        bus(32, 1'b0, 0);
        check(rd, 0);
        $display("defaults done");
    endtask
    task automatic t_torque;
        a_tq <= 16'sd5000;
        settle();
        check(torque_cmd, 500);
        wr(5, 1000);
        settle();
        check(torque_cmd, 400);
        wr(1, 50);
        wr(2, -80);
        wr(3, 30);
        tq_code <= 2'h1;
        settle();
        check(torque_cmd, 500);
        tq_code <= 2'h2;
        settle();
        check(torque_cmd, -800);
        check(tq_basic, 400);
        tq_code <= 2'h3;
        settle();
        check(torque_cmd, 300);
        $display("torque sources done");
    endtask
    task automatic t_limits;
        tq_code <= 2'h2;
        wr(7, 60);
        wr(8, 40);
        settle();
        check(torque_cmd, -600);
        tl_on <= 1'b1;
        settle();
        check(torque_limit_act, 60);
        wr(0, 5);
        settle();
        check(torque_limit_act, 40);
        check(torque_cmd, -400);
        wr(8, 90);
        settle();
        check(torque_limit_act, 60);
        ce <= 1'b0;
        tq_code <= 2'h3;
        repeat (10) @(posedge hclk);
        check(torque_cmd, -600);
        ce <= 1'b1;
        tq_code <= 2'h2;
        tl_on <= 1'b0;
        wr(7, 100);
        $display("limits done");
    endtask
    task automatic t_speed;
        a_sp <= 16'sd5000;
        for (int m = 0; m < 2; m++) begin
            wr(0, 4 + 2 * m);
            for (int c = 0; c < 8; c++) begin
                spd_code <= 3'(c);
                settle();
                check(speed_limit, m ? spd_b[c] : spd_a[c]);
            end
        end
        a_sp <= -16'sd10000;
        spd_code <= 3'h0;
        settle();
        check(speed_limit, 3000);
        wr(9, 7000);
        spd_code <= 3'h1;
        settle();
        check(speed_limit, 6000);
        spd_code <= 3'h0;
        a_sp <= 16'sh0;
        $display("speed limits done");
    endtask
    task automatic t_filter;
        wr(6, 5000);
        tq_code <= 2'h1;
        settle();
        check(torque_cmd < -16'sd700, 1'b1);
        wr(6, 0);
        settle();
        check(torque_cmd, 500);
        wr(6, 5000);
        wr(0, 0);
        tq_code <= 2'h2;
        repeat (3) @(posedge hclk);
        check(torque_cmd, -800);
        $display("filter done");
    endtask
    task automatic t_interp;
        wr(0, 32'h14);
        settle();
        wr(17, 50);
        bus(17, 1'b0, 0);
        check(rd, 32'h0123);
        wr(18, 100);
        bus(18, 1'b0, 0);
        check(rd, 100);
        wr(0, 32'h24);
        settle();
        wr(17, 50);
        bus(17, 1'b0, 0);
        check(rd, 50);
        bus(19, 1'b0, 0);
        check(rd, 32'h0456);
        $display("interpolation done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Watchdog and main sequence
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_defaults();
        t_torque();
        t_limits();
        t_speed();
        t_filter();
        t_interp();
        complete_run();
    end
endmodule
